// ### src/stc_pkg.sv
// Package for the sampler thermal fan and pump controller.
// Assumes temperatures arrive as signed readings in tenths of a degree C.
package stc_pkg;
  localparam int          TEMP_W        = 12;
  localparam logic [11:0] FAN_DELTA     = 12'h014;  // 2.0 C
  localparam logic [11:0] PFAN_START    = 12'h096;  // 15.0 C
  localparam logic [11:0] PFAN_STOP     = 12'h064;  // 10.0 C
  localparam logic [11:0] COLD_LIMIT    = 12'h064;  // 10.0 C
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          COLD_TIME_S   = 30;
  localparam longint      COLD_CYCLES   = longint'(COLD_TIME_S) * longint'(CLK_HZ);

  typedef enum logic [1:0] {STC_AUTO, STC_ON, STC_OFF} stc_mode_t;

  typedef struct packed {
    logic             valid;
    logic signed [11:0] filt;
    logic signed [11:0] amb;
  } stc_reading_t;

  typedef struct packed {
    logic filt_fan;
    logic pump_fan;
    logic pump;
    logic vent_valve;
  } stc_cmd_t;
endpackage

// ### src/stc_cold_timer.sv
// Low-ambient timer: counts cycles while cold, restarts when cold lapses.
// Assumes cold/arm come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module stc_cold_timer #(
  parameter longint LIMIT = stc_pkg::COLD_CYCLES
) (
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Condition
  input  wire logic cold,
  input  wire logic arm,
  // Result
  output logic      expired
);
  initial if (LIMIT < 1) $error("LIMIT must be at least 1");
  logic [39:0] cnt;
  logic [39:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (!cold || !arm) next_cnt = '0;
    else if (cnt < 40'(LIMIT)) next_cnt = cnt + 40'h1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt <= '0;
    else if (ce) cnt <= next_cnt;
  end
  assign expired = (cnt >= 40'(LIMIT));
endmodule
`default_nettype wire

// ### src/stc_ctrl.sv
// Thermal fan and pump controller top level.
// Assumes readings and controls are synchronous to ref_clk; sampling is a pin.
`timescale 1ns/1ps
`default_nettype none
module stc_ctrl #(
  parameter longint COLD_CYCLES = stc_pkg::COLD_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  // Configuration and state
  input  wire stc_pkg::stc_mode_t    fan_mode,
  input  wire logic                  fan_mode_load,
  input  wire logic                  sampling_pin,
  // Sensor readings
  input  wire stc_pkg::stc_reading_t rd,
  // Actuator commands and current fan mode
  output var stc_pkg::stc_cmd_t      cmd,
  output var stc_pkg::stc_mode_t     mode_now
);
  initial if (COLD_CYCLES < 1) $error("COLD_CYCLES must be at least 1");

  logic rst_s1, rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  logic samp_s1, sampling;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_s1  <= 1'b0;
      sampling <= 1'b0;
    end else if (ce) begin
      samp_s1  <= sampling_pin;
      sampling <= samp_s1;
    end
  end

  typedef enum logic [1:0] {ST_POWERUP, ST_IDLE, ST_COLD} stc_pst_t;
  stc_pst_t  pst, next_pst;
  stc_pkg::stc_mode_t next_mode;
  stc_pkg::stc_cmd_t  next_cmd;
  logic signed [12:0] amb_x, filt_x;
  logic cold, warm, expired;
  // Cold level held between readings so the timer is not restarted by gaps
  logic cmd_cold_hold, next_cold_hold;

  assign amb_x  = 13'(rd.amb);
  assign filt_x = 13'(rd.filt);
  assign cold   = rd.valid && (rd.amb < $signed(stc_pkg::COLD_LIMIT));
  assign warm   = rd.valid && (rd.amb > $signed(stc_pkg::COLD_LIMIT));

  stc_cold_timer #(.LIMIT(COLD_CYCLES)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .cold    (cold || (!rd.valid && pst == ST_IDLE && !warm && cmd_cold_hold)),
    .arm     (pst == ST_IDLE && !sampling),
    .expired (expired)
  );

  always_comb begin
    next_mode      = mode_now;
    next_pst       = pst;
    next_cmd       = cmd;
    next_cold_hold = cmd_cold_hold;
    if (rd.valid) next_cold_hold = cold;
    if (fan_mode_load && fan_mode != 2'h3) next_mode = fan_mode;
    unique case (mode_now)
      stc_pkg::STC_ON:  next_cmd.filt_fan = 1'b1;
      stc_pkg::STC_OFF: next_cmd.filt_fan = 1'b0;
      default: begin
        if (rd.valid && filt_x > amb_x + $signed(13'(stc_pkg::FAN_DELTA)))
          next_cmd.filt_fan = 1'b1;
        else if (rd.valid && filt_x < amb_x)
          next_cmd.filt_fan = 1'b0;
      end
    endcase
    unique case (pst)
      ST_POWERUP: if (rd.valid && !cold) next_pst = ST_IDLE;
      ST_IDLE:    if (expired && !sampling) next_pst = ST_COLD;
      ST_COLD:    if (warm) next_pst = ST_IDLE;
      default:    next_pst = ST_IDLE;
    endcase
    next_cmd.pump = sampling || next_pst != ST_IDLE;
    next_cmd.vent_valve = !sampling && next_pst != ST_IDLE;
    if (!next_cmd.pump) next_cmd.pump_fan = 1'b0;
    else if (rd.valid && rd.filt > $signed(stc_pkg::PFAN_START))
      next_cmd.pump_fan = 1'b1;
    else if (rd.valid && rd.filt < $signed(stc_pkg::PFAN_STOP))
      next_cmd.pump_fan = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_now      <= stc_pkg::STC_AUTO;
      pst           <= ST_POWERUP;
      cmd           <= 4'h3;  // pump on, fans off, vent on
      cmd_cold_hold <= 1'b0;
    end else if (ce) begin
      mode_now      <= next_mode;
      pst           <= next_pst;
      cmd           <= next_cmd;
      cmd_cold_hold <= next_cold_hold;
    end
  end

  a_pfan_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.pump_fan |-> cmd.pump) else $error("pump fan without pump");
  a_pump_samp: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && sampling |=> cmd.pump) else $error("pump off while sampling");
  a_fan_forced: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && mode_now == stc_pkg::STC_ON |=> cmd.filt_fan) else $error("fan not on");
  a_fan_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && mode_now == stc_pkg::STC_OFF |=> !cmd.filt_fan) else $error("fan not off");
  a_auto_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && mode_now == stc_pkg::STC_AUTO && rd.valid && filt_x > amb_x + 13'sd20
    |=> cmd.filt_fan) else $error("auto fan missed on");
  a_auto_offf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && mode_now == stc_pkg::STC_AUTO && rd.valid && filt_x < amb_x
    |=> !cmd.filt_fan) else $error("auto fan missed off");
  a_pfan_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && rd.valid && rd.filt < 12'sd100 |=> !cmd.pump_fan) else $error("pfan stop");
  a_vent_cold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cmd.vent_valve |-> cmd.pump) else $error("vent without pump");
  c_cold_start: cover property (@(posedge ref_clk) pst == ST_IDLE ##1 pst == ST_COLD);
  c_pfan_on:    cover property (@(posedge ref_clk) !cmd.pump_fan ##1 cmd.pump_fan);
  c_auto_fan:   cover property (@(posedge ref_clk) !cmd.filt_fan ##1 cmd.filt_fan);
  c_samp_pump:  cover property (@(posedge ref_clk) !sampling ##1 sampling);
endmodule
`default_nettype wire

// ### testbench/stc_sensor_model.sv
// Sensor front end model: turns a bench request into one valid reading pulse.
// Assumes requests are raised on ref_clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module stc_sensor_model (
  // Clock and request
  input  wire logic                  ref_clk,
  input  wire logic                  go,
  input  wire logic [11:0]           f_in,
  input  wire logic [11:0]           a_in,
  // Reading to the controller
  output var stc_pkg::stc_reading_t  rd
);
  initial rd = '0;
  // Idle fields toggle so a stale value never passes for a fresh reading
  always @(posedge ref_clk) begin
    rd.valid <= go;
    rd.filt  <= go ? f_in : ~rd.filt;
    rd.amb   <= go ? a_in : ~rd.amb;
  end
endmodule
`default_nettype wire

// ### testbench/tb_sampler_thermal_fan_pump_control.sv
// Bench for the thermal controller: scenario tasks, self-checking.
// Assumes the sensor model answers each request with one reading.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_sampler_thermal_fan_pump_control;
  logic                 clk = 1'b0, rstn = 1'b0, ce = 1'b1, load = 1'b0, samp = 1'b0, go = 1'b0;
  logic [11:0]          f = 12'h000, a = 12'h000;
  stc_pkg::stc_mode_t   fan_mode = stc_pkg::STC_AUTO, mode_now;
  stc_pkg::stc_reading_t rd;
  stc_pkg::stc_cmd_t    cmd;
  int                   err_count = 0, n_tests = 0;
  always #5 clk = ~clk;
  stc_sensor_model i_stc_sensor_model (.ref_clk(clk), .go(go), .f_in(f), .a_in(a), .rd(rd));
  // Short cold count keeps the run brief
  stc_ctrl #(.COLD_CYCLES(50)) i_stc_ctrl (.ref_clk(clk), .rstn(rstn), .ce(ce),
    .fan_mode(fan_mode), .fan_mode_load(load), .sampling_pin(samp), .rd(rd),
    .cmd(cmd), .mode_now(mode_now));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdg(input logic [11:0] fv, input logic [11:0] av);
    @(posedge clk) begin go <= 1'b1; f <= fv; a <= av; end
    @(posedge clk) go <= 1'b0;
    wt(2);
  endtask
  task automatic ld(input stc_pkg::stc_mode_t m);
    @(posedge clk) begin fan_mode <= m; load <= 1'b1; end
    @(posedge clk) load <= 1'b0;
    wt(1);
  endtask
  task automatic t_auto;
    rdg(12'h0C8, 12'h0C8); `CHK("pump", 1'b0, cmd.pump)
    rdg(12'h0DD, 12'h0C8); `CHK("ffan", 1'b1, cmd.filt_fan)
    `CHK("pfan", 1'b0, cmd.pump_fan)
    rdg(12'h0D2, 12'h0C8); `CHK("ffan", 1'b1, cmd.filt_fan)
    rdg(12'h0BE, 12'h0C8); `CHK("ffan", 1'b0, cmd.filt_fan)
    rdg(12'h0D2, 12'h0C8); `CHK("ffan", 1'b0, cmd.filt_fan)
  endtask
  task automatic t_modes;
    ld(stc_pkg::STC_ON); rdg(12'h0BE, 12'h0C8); `CHK("ffan", 1'b1, cmd.filt_fan)
    `CHK("mode", stc_pkg::STC_ON, mode_now)
    ld(stc_pkg::STC_OFF); rdg(12'h0FF, 12'h0C8); `CHK("ffan", 1'b0, cmd.filt_fan)
    ld(stc_pkg::stc_mode_t'(2'h3)); `CHK("mode", stc_pkg::STC_OFF, mode_now)
    ld(stc_pkg::STC_AUTO); `CHK("mode", stc_pkg::STC_AUTO, mode_now)
  endtask
  task automatic t_samp;
    @(posedge clk) samp <= 1'b1;
    wt(5); `CHK("pump", 1'b1, cmd.pump)
    `CHK("vent", 1'b0, cmd.vent_valve)
    rdg(12'h0A0, 12'h0C8); `CHK("pfan", 1'b1, cmd.pump_fan)
    rdg(12'h078, 12'h0C8); `CHK("pfan", 1'b1, cmd.pump_fan)
    rdg(12'h05A, 12'h0C8); `CHK("pfan", 1'b0, cmd.pump_fan)
    rdg(12'h078, 12'h0C8); `CHK("pfan", 1'b0, cmd.pump_fan)
    @(posedge clk) samp <= 1'b0;
    wt(5); `CHK("pump", 1'b0, cmd.pump)
  endtask
  // A reading offered while the enable is low must leave the fan alone
  task automatic t_ce;
    @(posedge clk) ce <= 1'b0;
    rdg(12'h0FF, 12'h0C8); `CHK("ffan", 1'b0, cmd.filt_fan)
    @(posedge clk) ce <= 1'b1;
    wt(1);
  endtask
  task automatic t_cold;
    rdg(12'h064, 12'h032); wt(30);
    rdg(12'h064, 12'h096); rdg(12'h064, 12'h032);
    wt(30); `CHK("pump", 1'b0, cmd.pump)
    wt(30); `CHK("pump", 1'b1, cmd.pump)
    `CHK("vent", 1'b1, cmd.vent_valve)
    rdg(12'h064, 12'h06E); `CHK("pump", 1'b0, cmd.pump)
  endtask
  task automatic test_done;
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    err_count++;
    test_done();
  end
  initial begin
    wt(19); `CHK("cmd", 4'h3, cmd)
    `CHK("mode", stc_pkg::STC_AUTO, mode_now)
    @(posedge clk) rstn <= 1'b1;
    wt(3);
    t_auto(); t_modes(); t_samp(); t_ce(); t_cold();
    test_done();
  end
endmodule
`default_nettype wire
